// ### rtl/btb_pkg.sv
// Package with constants and carrier structs for the beeper and timebase block.
package btb_pkg;

    // Beeper divisions of the oscillator clock.
    localparam int unsigned BEEP_DIV_LOW  = 4000;
    localparam int unsigned BEEP_DIV_MID  = 8000;
    localparam int unsigned BEEP_DIV_HIGH = 16000;

    // Timebase periods in oscillator cycles.
    localparam int unsigned TB_PERIOD_0 = 16000;
    localparam int unsigned TB_PERIOD_1 = 32000;
    localparam int unsigned TB_PERIOD_2 = 80000;
    localparam int unsigned TB_PERIOD_3 = 200000;

    // Counter width that holds the longest count.
    localparam int unsigned CNT_W = 18;

    // Beeper select encodings.
    localparam logic [1:0] BEEP_SEL_OFF  = 2'h0;
    localparam logic [1:0] BEEP_SEL_LOW  = 2'h1;
    localparam logic [1:0] BEEP_SEL_MID  = 2'h2;
    localparam logic [1:0] BEEP_SEL_HIGH = 2'h3;

    // Reset values.
    localparam logic [1:0] TB_SEL_RESET = 2'h0;

    // Power modes, Gray coded along run -> clocked halt -> full halt.
    typedef enum logic [1:0]
    {
        BTB_RUN         = 2'b00,
        BTB_ACTIVE_HALT = 2'b01,
        BTB_HALT        = 2'b11
    } btb_mode_e;

    // Software controls of the block.
    typedef struct packed
    {
        logic [1:0] beep_sel;
        logic [1:0] timebase_period_select;
        logic       irq_enable;
        logic       irq_clear;
        logic       active_halt_req;
        logic       halt_req;
        logic       wake;
    } btb_ctrl_s;

    // Status presented back to the core.
    typedef struct packed
    {
        logic       beeper;
        logic       irq;
        logic       irq_flag;
        logic       clock_output_run;
        logic       core_halted;
        btb_mode_e  mode;
    } btb_stat_s;

endpackage

// ### rtl/btb_divider.sv
// Free running divider that produces a terminal pulse every 'period' cycles.
`timescale 1ns/10ps
module btb_divider #(
    parameter int unsigned W = 18
)
(
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Period in cycles, compared with the count in every cycle.
    input  wire logic [W-1:0] period,
    // Count status.
    output logic [W-1:0]      count,
    output logic              wrap
);

    // Refuse a width too narrow to hold any useful period.
    if (W < 2)
    begin : g_width_check
        $error("btb_divider needs at least two bits");
    end

    // State of the divider.
    typedef struct packed
    {
        logic [W-1:0] cnt;
    } btb_div_s;

    btb_div_s state_reg;
    btb_div_s state_next;

    // Count up to period minus one, then wrap to zero.
    always_comb
    begin
        state_next = state_reg;
        if (wrap)
            state_next.cnt = '0;
        else
            state_next.cnt = state_reg.cnt + W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign count = state_reg.cnt;
    assign wrap  = (state_reg.cnt >= period - W'(1));

endmodule

// ### rtl/btb_beeper_timebase.sv
// Beeper generator, oscillator timebase interrupt and power mode control.
`timescale 1ns/10ps
module btb_beeper_timebase #(
    parameter int unsigned TB_P0 = btb_pkg::TB_PERIOD_0,
    parameter int unsigned TB_P1 = btb_pkg::TB_PERIOD_1,
    parameter int unsigned TB_P2 = btb_pkg::TB_PERIOD_2,
    parameter int unsigned TB_P3 = btb_pkg::TB_PERIOD_3
)
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              reset,
    // Software controls.
    input  wire btb_pkg::btb_ctrl_s ctrl,
    // Outputs and status.
    output btb_pkg::btb_stat_s     stat
);

    localparam int unsigned W = btb_pkg::CNT_W;

    // Refuse periods that the counter cannot hold or that leave nothing to count.
    if (TB_P0 < 2 || TB_P1 < 2 || TB_P2 < 2 || TB_P3 < 2 ||
        TB_P0 >= (1 << W) || TB_P1 >= (1 << W) || TB_P2 >= (1 << W) || TB_P3 >= (1 << W))
    begin : g_period_check
        $error("Timebase period out of counter range");
    end

    // Period lookup for the latched selection, used by the divider and the period end check.
    function automatic logic [W-1:0] tb_period(input logic [1:0] sel);
        case (sel)
            2'h0:    tb_period = W'(TB_P0);
            2'h1:    tb_period = W'(TB_P1);
            2'h2:    tb_period = W'(TB_P2);
            default: tb_period = W'(TB_P3);
        endcase
    endfunction

    // Half of a beeper division, the toggle interval.
    function automatic logic [W-1:0] beep_half(input logic [1:0] sel);
        case (sel)
            btb_pkg::BEEP_SEL_LOW:  beep_half = W'(btb_pkg::BEEP_DIV_LOW / 2);
            btb_pkg::BEEP_SEL_MID:  beep_half = W'(btb_pkg::BEEP_DIV_MID / 2);
            default:                beep_half = W'(btb_pkg::BEEP_DIV_HIGH / 2);
        endcase
    endfunction

    // All state of the block except the timebase count, which lives in the divider.
    typedef struct packed
    {
        logic [1:0]        tb_sel;
        logic [W-1:0]      beep_cnt;
        logic              beeper;
        logic              irq_en;
        logic              flag;
        btb_pkg::btb_mode_e mode;
    } btb_state_s;

    btb_state_s   state_reg;
    btb_state_s   state_next;
    logic [W-1:0] tb_count;
    logic         tb_wrap;

    // Timebase counter runs free in every mode; the mask never reaches it.
    btb_divider #(
        .W      (W)
    ) u_timebase (
        .clk    (clk),
        .reset  (reset),
        .period (tb_period(state_reg.tb_sel)),
        .count  (tb_count),
        .wrap   (tb_wrap)
    );

    // Next state: beeper, flag, mask, period latch and power mode.
    always_comb
    begin
        state_next = state_reg;
        // A new period only lands on the wrap, so the running period never shifts.
        if (tb_wrap)
            state_next.tb_sel = ctrl.timebase_period_select;
        // Beeper keeps toggling whatever the power mode.
        if (ctrl.beep_sel == btb_pkg::BEEP_SEL_OFF)
        begin
            state_next.beep_cnt = '0;
            state_next.beeper   = 1'b0;
        end
        else if (state_reg.beep_cnt >= beep_half(ctrl.beep_sel) - W'(1))
        begin
            state_next.beep_cnt = '0;
            state_next.beeper   = ~state_reg.beeper;
        end
        else
            state_next.beep_cnt = state_reg.beep_cnt + W'(1);
        state_next.irq_en = ctrl.irq_enable;
        // Set wins over a clear in the same cycle, so no period is lost.
        if (tb_wrap)
            state_next.flag = 1'b1;
        else if (ctrl.irq_clear)
            state_next.flag = 1'b0;
        case (state_reg.mode)
            btb_pkg::BTB_RUN:
            begin
                if (ctrl.active_halt_req)
                begin
                    state_next.mode   = btb_pkg::BTB_ACTIVE_HALT;
                    state_next.irq_en = 1'b1;
                end
                else if (ctrl.halt_req)
                    state_next.mode = btb_pkg::BTB_HALT;
            end
            btb_pkg::BTB_ACTIVE_HALT:
            begin
                state_next.irq_en = 1'b1;
                if (ctrl.wake || (state_reg.flag && state_reg.irq_en))
                    state_next.mode = btb_pkg::BTB_RUN;
            end
            btb_pkg::BTB_HALT:
            begin
                // Only an external wake ends full halt; the timebase cannot.
                if (ctrl.wake)
                    state_next.mode = btb_pkg::BTB_RUN;
            end
            default: state_next.mode = btb_pkg::BTB_RUN;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg        <= '0;
            state_reg.tb_sel <= btb_pkg::TB_SEL_RESET;
            state_reg.mode   <= btb_pkg::BTB_RUN;
        end
        else
            state_reg <= state_next;
    end

    // Status is taken straight from registers, filled in one process so it has one driver.
    always_comb
    begin
        stat.beeper           = state_reg.beeper;
        stat.irq              = state_reg.flag & state_reg.irq_en;
        stat.irq_flag         = state_reg.flag;
        stat.clock_output_run = (state_reg.mode == btb_pkg::BTB_RUN);
        stat.core_halted      = (state_reg.mode != btb_pkg::BTB_RUN);
        stat.mode             = state_reg.mode;
    end

    // Assertions.
    sequence wrap_seen_s;
        tb_wrap;
    endsequence

    sequence flag_up_s;
        state_reg.flag;
    endsequence

    flag_sets_a: assert property (@(posedge clk) disable iff (reset)
        wrap_seen_s |=> flag_up_s) else $error("Flag not set after timebase wrap");

    flag_holds_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.flag && !ctrl.irq_clear |=> state_reg.flag) else $error("Flag dropped without clear");

    mask_gates_a: assert property (@(posedge clk) disable iff (reset)
        !state_reg.irq_en |-> !stat.irq) else $error("Masked interrupt reached output");

    counter_free_a: assert property (@(posedge clk) disable iff (reset)
        !tb_wrap |=> tb_count == $past(tb_count) + W'(1)) else $error("Timebase counter stalled");

    period_latch_a: assert property (@(posedge clk) disable iff (reset)
        !tb_wrap |=> $stable(state_reg.tb_sel)) else $error("Period changed mid period");

    halt_arms_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode == btb_pkg::BTB_RUN && ctrl.active_halt_req |=> state_reg.irq_en)
        else $error("Clocked halt entered without interrupt enable");

    halt_wake_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode == btb_pkg::BTB_HALT && !ctrl.wake |=> state_reg.mode == btb_pkg::BTB_HALT)
        else $error("Left full halt without wake");

    active_wake_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode == btb_pkg::BTB_ACTIVE_HALT && state_reg.flag |=> state_reg.mode == btb_pkg::BTB_RUN)
        else $error("Timebase did not wake clocked halt");

    clk_out_stops_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode == btb_pkg::BTB_ACTIVE_HALT |-> !stat.clock_output_run)
        else $error("Clock output running in clocked halt");

    // Each timebase wrap lands exactly on the last count of the latched period.
    period_end_a: assert property (@(posedge clk) disable iff (reset)
        tb_wrap |-> tb_count == tb_period(state_reg.tb_sel) - W'(1))
        else $error("Timebase wrapped off its period end");

    // Beeper steps: counting inside a half period, then the toggle point.
    sequence beep_counting_s;
        ctrl.beep_sel != btb_pkg::BEEP_SEL_OFF && state_reg.beep_cnt < beep_half(ctrl.beep_sel) - W'(1);
    endsequence

    sequence beep_toggle_point_s;
        ctrl.beep_sel != btb_pkg::BEEP_SEL_OFF && state_reg.beep_cnt == beep_half(ctrl.beep_sel) - W'(1);
    endsequence

    beep_hold_a: assert property (@(posedge clk) disable iff (reset)
        beep_counting_s |=> $stable(state_reg.beeper)) else $error("Beeper toggled inside a half period");

    beep_toggle_a: assert property (@(posedge clk) disable iff (reset)
        beep_toggle_point_s |=> $changed(state_reg.beeper)) else $error("Beeper missed its toggle point");

    beep_off_a: assert property (@(posedge clk) disable iff (reset)
        ctrl.beep_sel == btb_pkg::BEEP_SEL_OFF |=> !state_reg.beeper) else $error("Beeper running while off");

    // The beeper must not stall just because the core sleeps in clocked halt.
    beep_in_halt_a: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode == btb_pkg::BTB_ACTIVE_HALT && ctrl.beep_sel != btb_pkg::BEEP_SEL_OFF
        ##0 beep_toggle_point_s |=> $changed(state_reg.beeper)) else $error("Beeper stalled in clocked halt");

endmodule

// ### tb/btb_beeper_timebase_tb_top.sv
// Self-checking bench for the beeper and timebase block.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %0h seen %0h", nm, e, g); end end
module btb_beeper_timebase_tb_top;
    // Short timebase periods keep the run brief; expectations follow them.
    localparam int unsigned P [4] = '{20, 40, 60, 80};

    logic               clk = 1'b0;
    logic               reset = 1'b1;
    btb_pkg::btb_ctrl_s ctrl = '0;
    btb_pkg::btb_stat_s stat;
    int                 num_errors = 0;
    int                 checks_done = 0;
    int unsigned        prev;
    logic               seen_toggle = 1'b0;
    logic               last_beep = 1'b0;

    btb_beeper_timebase #(.TB_P0(P[0]), .TB_P1(P[1]), .TB_P2(P[2]), .TB_P3(P[3])) i_btb_beeper_timebase
    (
        .clk   (clk),
        .reset (reset),
        .ctrl  (ctrl),
        .stat  (stat)
    );

    // Clock of 4 ns period.
    always #2 clk = ~clk;

    // Note beeper edges seen while the core sits in clocked halt.
    always @(negedge clk)
    begin
        if (stat.mode === btb_pkg::BTB_ACTIVE_HALT && stat.beeper !== last_beep)
            seen_toggle <= 1'b1;
        last_beep <= stat.beeper;
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One falling edge of a bounded wait; running out of bound ends the run.
    task automatic tick(inout int n, input int lim);
        @(negedge clk);
        n++;
        if (n >= lim)
        begin
            num_errors++;
            end_of_test();
        end
    endtask

    // Clear held two edges, so a coinciding wrap still leaves a fresh flag.
    task automatic sync();
        int n;
        n = 0;
        ctrl.irq_clear = 1'b1;
        repeat (2) @(negedge clk);
        ctrl.irq_clear = 1'b0;
        while (stat.irq_flag !== 1'b1) tick(n, 400);
    endtask

    // Called just after a flag rise: clears it and counts cycles to the next.
    task automatic measure(input int unsigned exp);
        int n;
        n = 1;
        ctrl.irq_clear = 1'b1;
        @(negedge clk);
        ctrl.irq_clear = 1'b0;
        while (stat.irq_flag !== 1'b1) tick(n, 400);
        `CHK("timebase period", exp, n)
        `CHK("masked request", ctrl.irq_enable, stat.irq)
    endtask

    // A new select given mid-period only takes effect one period later.
    task automatic t_periods();
        int n;
        n = 0;
        while (stat.irq_flag !== 1'b1) tick(n, 400);
        measure(P[0]);
        prev = P[0];
        for (int i = 0; i < 4; i++)
        begin
            ctrl.timebase_period_select = 2'(3 - i);
            measure(prev);
            prev = P[3 - i];
        end
        measure(prev);
    endtask

    // Masked flag stays set across wraps; unmasking raises the request.
    task automatic t_mask();
        repeat (5 * prev - 1) @(negedge clk);
        `CHK("sticky flag", 1'b1, stat.irq_flag)
        `CHK("masked request", 1'b0, stat.irq)
        ctrl.irq_enable = 1'b1;
        @(negedge clk);
        `CHK("unmasked request", 1'b1, stat.irq)
        measure(prev);
    endtask

    // Measures one full high and low phase of the beeper.
    task automatic t_beep(input logic [1:0] sel, input int unsigned div);
        int n;
        ctrl.beep_sel = sel;
        n = 0;
        while (stat.beeper !== 1'b0) tick(n, div);
        while (stat.beeper !== 1'b1) tick(n, 2 * div);
        n = 0;
        while (stat.beeper === 1'b1) tick(n, div);
        `CHK("beeper high time", div / 2, n)
        n = 0;
        while (stat.beeper === 1'b0) tick(n, div);
        `CHK("beeper low time", div / 2, n)
    endtask

    // Clocked halt entries until a beeper edge falls inside one, then full halt.
    task automatic t_halt();
        int n;
        int k;
        ctrl.irq_enable = 1'b0;
        sync();
        k = 0;
        while (seen_toggle !== 1'b1 && k < 200)
        begin
            ctrl.irq_clear = 1'b1;
            ctrl.active_halt_req = 1'b1;
            @(negedge clk);
            ctrl.irq_clear = 1'b0;
            ctrl.active_halt_req = 1'b0;
            `CHK("clocked halt mode", btb_pkg::BTB_ACTIVE_HALT, stat.mode)
            `CHK("clock output", 1'b0, stat.clock_output_run)
            `CHK("core halted", 1'b1, stat.core_halted)
            n = 0;
            while (stat.mode !== btb_pkg::BTB_RUN) tick(n, 100);
            `CHK("wake flag", 1'b1, stat.irq_flag)
            `CHK("armed request", 1'b1, stat.irq)
            k++;
        end
        `CHK("beeper in halt", 1'b1, seen_toggle)
        ctrl.irq_clear = 1'b1;
        ctrl.halt_req = 1'b1;
        @(negedge clk);
        ctrl.irq_clear = 1'b0;
        ctrl.halt_req = 1'b0;
        repeat (200) @(negedge clk);
        `CHK("full halt kept", btb_pkg::BTB_HALT, stat.mode)
        ctrl.wake = 1'b1;
        @(negedge clk);
        ctrl.wake = 1'b0;
        `CHK("clock output", 1'b1, stat.clock_output_run)
        `CHK("core running", 1'b0, stat.core_halted)
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial
    begin
        repeat (2) @(negedge clk);
        `CHK("reset status", 7'h08, stat)
        reset = 1'b0;
        t_periods();
        t_mask();
        t_beep(btb_pkg::BEEP_SEL_HIGH, btb_pkg::BEEP_DIV_HIGH);
        t_beep(btb_pkg::BEEP_SEL_MID, btb_pkg::BEEP_DIV_MID);
        ctrl.beep_sel = btb_pkg::BEEP_SEL_OFF;
        repeat (2) @(negedge clk);
        `CHK("beeper off", 1'b0, stat.beeper)
        t_beep(btb_pkg::BEEP_SEL_LOW, btb_pkg::BEEP_DIV_LOW);
        t_halt();
        end_of_test();
    end
endmodule
